// ### ticket_cmd_map.svh
// Opcodes, frame lengths, offsets, reset values and timing counts of the ticket command block
`ifndef TICKET_CMD_MAP_SVH
`define TICKET_CMD_MAP_SVH

`define OP_INCR 8'hA5
`define OP_READ 8'h39
`define OP_PWD 8'h1B
`define OP_SIG 8'h3C
`define OP_TEAR 8'h3E
`define OP_VCS 8'h4B

`define LEN_INCR 5'h08
`define LEN_SHORT 5'h04
`define LEN_PWD 5'h07
`define LEN_VCS 5'h17

`define SEL_MAX 8'h02
`define CNT_FINAL 24'h0FFFFF
`define TEAR_OK 8'hBD
`define ACK_CODE 4'hA
`define NAK_ARG 4'h0
`define NAK_CRC 4'h1
`define CRC_INIT 16'h6363
`define SIG_LEN 6'h20

`define CLK_NS 10
`define BIT_NS 9440
`define RESP_BITS 9
`define COMMIT_CYC 3'h4

`define OFS_CONFIG 5'h00
`define OFS_PASSWORD 5'h04
`define OFS_ANSWER 5'h08
`define OFS_STATUS 5'h0C
`define OFS_COUNT0 5'h10
`define OFS_COUNT2 5'h18

`define RST_START 8'hFF
`define RST_PWD 32'hFFFFFFFF
`endif

// ### ticket_cmd_pkg.sv
// Types shared by the ticket command block
package ticket_cmd_pkg;
  typedef struct packed {
    logic [2:0] limit;
    logic protect_level_bit;
    logic [7:0] start;
  } cfg_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic nibble;
    logic [7:0] data;
  } tx_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rx_t;

  typedef enum logic [2:0] {
    ST_RX, ST_CHECK, ST_COMMIT, ST_WAIT, ST_SEND
  } state_t;

  typedef enum logic [1:0] {
    K_NONE, K_INCR, K_FAIL
  } commit_t;
endpackage

// ### ticket_cmd.sv
// Command interpreter for counters, password, signature, tear check, card select
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "ticket_cmd_map.svh"
// Contract
// - Increment is A5h, selector 00h-02h, then four amount bytes.
// - Only the low three amount bytes count; the top byte is dropped.
// - Counter stops at its final value; no increment passes it.
// - An increment beyond the final value gets NAK, counter untouched.
// - Zero increment is accepted and changes nothing.
// - Amount arrives least significant byte first; third byte is last used.
// - Increment commit is tear safe; a cut leaves the old value.
// - Answers start no sooner than nine bit times after frame end.
// - Password check is 1Bh plus four bytes; match returns two bytes.
// - Start page byte marks the first guarded page.
// - Level bit picks write-only or read and write guarding.
// - With nonzero limit, failed checks are counted tear safe.
// - At the limit, guarded access is refused for good.
// - Signature read is 3Ch, argument 00h, answer 32 bytes.
// - Signature is fixed at build; nothing changes it.
// - Tear check is 3Eh with selector; answer is one flag byte.
// - Flag BDh means no tearing; other values mean a tear.
// - After a tear a counter read gives the last committed value.
// - Card select is 4Bh with 16 and 4 bytes; only length checked.
// - Card select answers one card type byte.
// - Every frame ends in a two-byte CRC that the device checks.
// - Unauthenticated writes at or above start page are refused.
// - Counter read is 39h with selector; answer three bytes.
// - Counters read whatever the protection state.
module ticket_cmd #(
  parameter int RESP_DELAY_CYC =
    (`RESP_BITS * `BIT_NS + `CLK_NS - 1) / `CLK_NS,
  parameter logic [255:0] SIG_VALUE = {8{32'h5A5AC3C3}}, // Arbitrary value
  parameter logic [7:0] CARD_TYPE = 8'h01 // Arbitrary value
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset
  input wire logic [4:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [4:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire ticket_cmd_pkg::rx_t rx, // Received byte
  input wire logic rx_end, // Frame end pulse
  input wire logic field_lost, // Power cut level
  input wire logic session_end, // Drop authentication
  output ticket_cmd_pkg::tx_t tx, // Answer byte or nibble
  input wire logic tx_ready, // Framer takes tx
  input wire logic [7:0] page, // Page of access query
  input wire logic page_write, // Query is a write
  output logic page_ok // Query allowed
);
  import ticket_cmd_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  cfg_t cfg_reg;
  logic [31:0] pwd_reg;
  logic [15:0] pack_reg;
  logic [23:0] cnt_reg [0:2];
  logic [2:0] torn_reg;
  logic [2:0] fails_reg;
  logic auth_reg;
  logic locked;
  state_t state_reg;
  commit_t kind_reg;
  logic [4:0] len_reg;
  logic [7:0] op_reg;
  logic [7:0] arg_reg [0:4];
  logic [15:0] crc_reg;
  logic [13:0] wait_reg;
  logic [2:0] hold_reg;
  logic [1:0] sel_reg;
  logic [23:0] sum_reg;
  logic [7:0] buf_reg [0:31];
  logic [5:0] tlen_reg;
  logic [5:0] tidx_reg;
  logic tnib_reg;
  logic [3:0] code_reg;

  // ****************************************
  // Frame check
  // ****************************************
  function automatic logic [15:0] crc_step(
    input logic [15:0] c,
    input logic [7:0] d
  );
    logic [7:0] ch;
    ch = d ^ c[7:0];
    ch = ch ^ {ch[3:0], 4'h0};
    crc_step = {8'h00, c[15:8]} ^ {ch, 8'h00}
      ^ {5'h00, ch, 3'h0} ^ {12'h000, ch[7:4]};
  endfunction

  logic [7:0] sel_byte;
  logic [24:0] sum_full;
  logic len_ok;
  assign sel_byte = arg_reg[0];
  // Amount bytes 1..3 LSB first, byte 4 dropped
  assign sum_full = {1'b0, cnt_reg[sel_byte[1:0]]}
    + {1'b0, arg_reg[3], arg_reg[2], arg_reg[1]};
  assign locked = (cfg_reg.limit != 3'h0)
    && (fails_reg >= cfg_reg.limit);

  always_comb begin
    case (op_reg)
      `OP_INCR: len_ok = (len_reg == `LEN_INCR);
      `OP_PWD: len_ok = (len_reg == `LEN_PWD);
      `OP_VCS: len_ok = (len_reg == `LEN_VCS);
      default: len_ok = (len_reg == `LEN_SHORT);
    endcase
  end

  // ****************************************
  // Receive
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      len_reg <= 5'h00;
      op_reg <= 8'h00;
      crc_reg <= `CRC_INIT;
    end else if (state_reg == ST_RX && rx.valid) begin
      crc_reg <= crc_step(crc_reg, rx.data);
      if (len_reg != 5'h1F) begin
        len_reg <= len_reg + 5'h01;
      end
      if (len_reg == 5'h00) begin
        op_reg <= rx.data;
      end
    end else if (state_reg == ST_SEND) begin
      len_reg <= 5'h00;
      crc_reg <= `CRC_INIT;
    end else if (state_reg == ST_RX && rx_end) begin
      len_reg <= 5'h00;
      crc_reg <= `CRC_INIT;
    end
  end

  generate
    for (genvar i = 0; i < 5; i++) begin : g_arg
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          arg_reg[i] <= 8'h00;
        end else if (state_reg == ST_RX && rx.valid
            && len_reg == 5'(i + 1)) begin
          arg_reg[i] <= rx.data;
        end
      end
    end
  endgenerate

  // ****************************************
  // Command sequencer
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_RX;
      wait_reg <= 14'h0000;
    end else begin
      case (state_reg)
        ST_RX: begin
          wait_reg <= 14'h0000;
          if (rx_end && len_reg != 5'h00) begin
            state_reg <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          wait_reg <= wait_reg + 14'h0001;
          state_reg <= (kind_reg != K_NONE) ? ST_COMMIT : ST_WAIT;
        end
        ST_COMMIT: begin
          wait_reg <= wait_reg + 14'h0001;
          if (field_lost) begin
            state_reg <= ST_RX;
          end else if (hold_reg == `COMMIT_CYC) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (wait_reg >= 14'(RESP_DELAY_CYC - 1)) begin
            state_reg <= ST_SEND;
          end else begin
            wait_reg <= wait_reg + 14'h0001;
          end
        end
        ST_SEND: begin
          if (tx.valid && tx.last && tx_ready) begin
            state_reg <= ST_RX;
          end
        end
        default: state_reg <= ST_RX;
      endcase
    end
  end

  // ****************************************
  // Decode and answer
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kind_reg <= K_NONE;
      tlen_reg <= 6'h00;
      tnib_reg <= 1'b0;
      code_reg <= `NAK_ARG;
      sel_reg <= 2'h0;
      sum_reg <= 24'h000000;
    end else if (state_reg == ST_RX && rx_end) begin
      kind_reg <= K_NONE;
      tnib_reg <= 1'b1;
      code_reg <= `NAK_ARG;
      tlen_reg <= 6'h01;
      sel_reg <= sel_byte[1:0];
      sum_reg <= sum_full[23:0];
      if (crc_reg != 16'h0000) begin
        code_reg <= `NAK_CRC;
      end else if (!len_ok) begin
        code_reg <= `NAK_ARG;
      end else begin
        case (op_reg)
          `OP_INCR: begin
            if (sel_byte <= `SEL_MAX
                && sum_full <= {1'b0, `CNT_FINAL}) begin
              code_reg <= `ACK_CODE;
              kind_reg <= K_INCR;
            end
          end
          `OP_READ: begin
            if (sel_byte <= `SEL_MAX) begin
              tnib_reg <= 1'b0;
              tlen_reg <= 6'h03;
            end
          end
          `OP_PWD: begin
            if (!locked && {arg_reg[3], arg_reg[2],
                arg_reg[1], arg_reg[0]} == pwd_reg) begin
              tnib_reg <= 1'b0;
              tlen_reg <= 6'h02;
            end else if (!locked && cfg_reg.limit != 3'h0) begin
              kind_reg <= K_FAIL;
            end
          end
          `OP_SIG: begin
            if (sel_byte == 8'h00) begin
              tnib_reg <= 1'b0;
              tlen_reg <= `SIG_LEN;
            end
          end
          `OP_TEAR: begin
            if (sel_byte <= `SEL_MAX) begin
              tnib_reg <= 1'b0;
              tlen_reg <= 6'h01;
            end
          end
          `OP_VCS: begin
            tnib_reg <= 1'b0;
            tlen_reg <= 6'h01;
          end
          default: code_reg <= `NAK_ARG;
        endcase
      end
    end
  end

  // Answer bytes are captured in ST_CHECK, one cycle after the frame is judged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 32; i++) begin
        buf_reg[i] <= 8'h00;
      end
    end else if (state_reg == ST_CHECK) begin
      case (op_reg)
        `OP_READ: begin
          buf_reg[0] <= cnt_reg[sel_reg][7:0];
          buf_reg[1] <= cnt_reg[sel_reg][15:8];
          buf_reg[2] <= cnt_reg[sel_reg][23:16];
        end
        `OP_PWD: begin
          buf_reg[0] <= pack_reg[7:0];
          buf_reg[1] <= pack_reg[15:8];
        end
        `OP_SIG: begin
          for (int i = 0; i < 32; i++) begin
            buf_reg[i] <= SIG_VALUE[8 * i +: 8];
          end
        end
        `OP_TEAR: begin
          buf_reg[0] <= torn_reg[sel_reg] ? 8'h00 : `TEAR_OK;
        end
        `OP_VCS: buf_reg[0] <= CARD_TYPE;
        default: buf_reg[0] <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Tear-safe commit
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_reg <= 3'h0;
    end else if (state_reg == ST_COMMIT) begin
      hold_reg <= hold_reg + 3'h1;
    end else begin
      hold_reg <= 3'h0;
    end
  end

  // New value lands only after the full commit window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 3; i++) begin
        cnt_reg[i] <= 24'h000000;
      end
      torn_reg <= 3'h0;
    end else if (state_reg == ST_COMMIT && kind_reg == K_INCR) begin
      if (field_lost) begin
        torn_reg[sel_reg] <= 1'b1;
      end else if (hold_reg == `COMMIT_CYC) begin
        cnt_reg[sel_reg] <= sum_reg;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fails_reg <= 3'h0;
    end else if (state_reg == ST_COMMIT && kind_reg == K_FAIL
        && !field_lost && hold_reg == `COMMIT_CYC) begin
      fails_reg <= fails_reg + 3'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auth_reg <= 1'b0;
    end else if (state_reg == ST_CHECK && op_reg == `OP_PWD
        && !tnib_reg) begin
      auth_reg <= 1'b1;
    end else if (session_end) begin
      auth_reg <= 1'b0;
    end
  end

  // ****************************************
  // Transmit
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx <= '0;
      tidx_reg <= 6'h00;
    end else if (state_reg == ST_SEND) begin
      if (!tx.valid || tx_ready) begin
        tx.valid <= !(tx.valid && tx.last);
        tx.nibble <= tnib_reg;
        tx.last <= (tidx_reg + 6'h01 == tlen_reg);
        tx.data <= tnib_reg ? {4'h0, code_reg} : buf_reg[tidx_reg[4:0]];
        tidx_reg <= tidx_reg + 6'h01;
      end
    end else begin
      tx <= '0;
      tidx_reg <= 6'h00;
    end
  end

  // ****************************************
  // Page access guard
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_ok <= 1'b0;
    end else if (page < cfg_reg.start) begin
      page_ok <= 1'b1;
    end else if (!page_write && !cfg_reg.protect_level_bit) begin
      page_ok <= 1'b1;
    end else begin
      page_ok <= auth_reg && !locked;
    end
  end

  // ****************************************
  // Bus slave
  // ****************************************
  logic wr_hs;
  logic rd_hs;
  logic [31:0] wmask;
  assign wr_hs = awready && awvalid && wready && wvalid;
  assign rd_hs = arready && arvalid;
  assign wmask = {{8{wstrb[3]}}, {8{wstrb[2]}},
    {8{wstrb[1]}}, {8{wstrb[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else begin
      awready <= awvalid && wvalid && !awready && !bvalid;
      wready <= awvalid && wvalid && !awready && !bvalid;
      if (wr_hs) begin
        bvalid <= 1'b1;
        bresp <= (awaddr <= `OFS_ANSWER) ? 2'h0 : 2'h2;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= '{limit: 3'h0, protect_level_bit: 1'b0, start: `RST_START};
      pwd_reg <= `RST_PWD;
      pack_reg <= 16'h0000;
    end else if (wr_hs) begin
      case (awaddr)
        `OFS_CONFIG: cfg_reg <= 12'((12'(cfg_reg) & ~wmask[11:0])
          | (wdata[11:0] & wmask[11:0]));
        `OFS_PASSWORD: pwd_reg <= (pwd_reg & ~wmask) | (wdata & wmask);
        `OFS_ANSWER: pack_reg <= (pack_reg & ~wmask[15:0])
          | (wdata[15:0] & wmask[15:0]);
        default: pack_reg <= pack_reg;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'h0;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (rd_hs) begin
        rvalid <= 1'b1;
        rresp <= 2'h0;
        case (araddr)
          `OFS_CONFIG: rdata <= {20'h00000, cfg_reg};
          `OFS_PASSWORD: rdata <= 32'h00000000;
          `OFS_ANSWER: rdata <= {16'h0000, pack_reg};
          `OFS_STATUS: rdata <= {24'h000000, torn_reg,
            locked, fails_reg, auth_reg};
          default: begin
            if (araddr >= `OFS_COUNT0 && araddr <= `OFS_COUNT2
                && araddr[1:0] == 2'h0) begin
              rdata <= {8'h00, cnt_reg[araddr[3:2]]};
            end else begin
              rdata <= 32'h00000000;
              rresp <= 2'h2;
            end
          end
        endcase
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule

// ### ticket_cmd_props.sv
// Port properties of the ticket command block
`timescale 1ns/10ps
module ticket_cmd_props #(
  parameter int RESP_DELAY_CYC = 20
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset
  input wire logic [4:0] awaddr, // Wr address
  input wire logic awvalid, // Wr addr valid
  input wire logic awready, // Wr addr ready
  input wire logic wvalid, // Wr data valid
  input wire logic wready, // Wr data ready
  input wire logic [1:0] bresp, // Wr response
  input wire logic bvalid, // Wr resp valid
  input wire logic bready, // Wr resp ready
  input wire logic arvalid, // Rd addr valid
  input wire logic arready, // Rd addr ready
  input wire logic [31:0] rdata, // Rd data
  input wire logic rvalid, // Rd valid
  input wire logic rready, // Rd ready
  input wire logic rx_end, // Frame end
  input wire ticket_cmd_pkg::tx_t tx, // Answer word
  input wire logic tx_ready // Framer ready
);
  import ticket_cmd_pkg::*;
  logic [15:0] gap;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles since frame end
  always_ff @(posedge aclk) begin
    if (!aresetn || rx_end) gap <= 16'h0000;
    else if (gap != 16'hFFFF) gap <= gap + 16'h0001;
  end
  a_reply_gap: assert property ($rose(tx.valid) |-> gap >= RESP_DELAY_CYC - 1)
    else $error("reply too soon after frame end");
  a_tx_hold: assert property (tx.valid && !tx_ready |=> tx.valid && $stable(tx))
    else $error("answer word changed before taken");
  a_nak_alone: assert property (tx.valid && tx.nibble |-> tx.last)
    else $error("short answer not last");
  a_wr_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write response late");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rd_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_ro_slverr: assert property (awvalid && awready && awaddr > 5'h08 |=> bresp == 2'h2)
    else $error("read-only write not refused");
  a_aw_pulse: assert property (awready |=> !awready)
    else $error("write ready held");
  c_nib: cover property (tx.valid && tx.nibble && tx_ready);
  c_data: cover property (tx.valid && tx.last && !tx.nibble && tx_ready);
  c_err: cover property (bvalid && bresp == 2'h2);
endmodule

// ### reader_model.sv
// Reader model: frames commands with CRC, collects answers
`timescale 1ns/10ps
`include "ticket_cmd_map.svh"
module reader_model (
  input wire logic aclk, // Clock
  output ticket_cmd_pkg::rx_t rx, // Byte to block
  output logic rx_end, // Frame end
  input wire ticket_cmd_pkg::tx_t tx, // Answer word
  output logic tx_ready // Take answer
);
  import ticket_cmd_pkg::*;
  typedef logic [7:0] bq_t[$];
  typedef logic [8:0] rq_t[$];
  logic slow = 1'b0;
  initial begin
    rx = '0;
    rx_end = 1'b0;
    tx_ready = 1'b0;
  end
  // Stall every other cycle in slow mode
  always @(posedge aclk) tx_ready <= slow ? !tx_ready : 1'b1;
  function automatic logic [15:0] crc_a(input bq_t q);
    logic [15:0] c;
    logic [7:0] b;
    c = `CRC_INIT;
    foreach (q[i]) begin
      b = q[i] ^ c[7:0];
      b = b ^ {b[3:0], 4'h0};
      c = {8'h00, c[15:8]} ^ {b, 8'h00} ^ {5'h00, b, 3'h0} ^ {12'h000, b[7:4]};
    end
    return c;
  endfunction
  task automatic send(input bq_t q, input logic bad);
    logic [15:0] c;
    c = crc_a(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      @(posedge aclk);
      rx <= {1'b1, q[i]};
    end
    @(posedge aclk);
    rx <= {1'b0, ~rx.data};
    rx_end <= 1'b1;
    @(posedge aclk);
    rx_end <= 1'b0;
  endtask
  // Bounded wait for the answer
  task automatic recv(input int lim, output rq_t r);
    r = {};
    repeat (lim) begin
      @(posedge aclk);
      if (tx.valid && tx_ready) begin
        r.push_back({tx.nibble, tx.nibble ? {4'h0, tx.data[3:0]} : tx.data});
        if (tx.last) break;
      end
    end
  endtask
endmodule

// ### ticket_cmd_tb.sv
// Testbench of the ticket command block
`timescale 1ns/10ps
`include "ticket_cmd_map.svh"
module ticket_cmd_tb;
  import ticket_cmd_pkg::*;
  typedef logic [7:0] bq_t[$];
  typedef logic [8:0] rq_t[$];
  localparam int DLY = 20;
  localparam logic [255:0] SIG = {8{32'h0F1E2D3C}}; // Arbitrary value
  localparam logic [7:0] CT = 8'h5C; // Arbitrary value
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rx_end, tx_ready, page_ok;
  logic [1:0] bresp, rresp;
  logic field_lost = 1'b0, session_end = 1'b0, page_write = 1'b0;
  logic [7:0] page = 8'h00;
  rx_t rx;
  tx_t tx;
  rq_t se, none;
  bq_t vq;
  int n_errors = 0;
  int num_checks = 0;
  always #5 aclk = ~aclk;
  ticket_cmd #(.RESP_DELAY_CYC(DLY), .SIG_VALUE(SIG), .CARD_TYPE(CT)) ticket_cmd_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rx(rx), .rx_end(rx_end), .field_lost(field_lost), .session_end(session_end),
    .tx(tx), .tx_ready(tx_ready), .page(page), .page_write(page_write), .page_ok(page_ok));
  reader_model reader_model_i (.aclk(aclk), .rx(rx), .rx_end(rx_end), .tx(tx),
    .tx_ready(tx_ready));
  task automatic results;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tmo;
    n_errors++;
    $display("BAD %0t wait ran out", $time);
    results();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_q(input rq_t g, input rq_t e);
    bit ok;
    ok = g.size() == e.size();
    foreach (e[i]) if (ok && g[i] !== e[i]) ok = 0;
    num_checks++;
    if (!ok) begin
      n_errors++;
      $display("BAD %0t reply %p exp %p", $time, g, e);
    end
  endtask
  function automatic rq_t nib(input logic [3:0] c);
    return '{{5'h10, c}};
  endfunction
  task automatic cmd(input bq_t c, input rq_t e, input logic bad = 1'b0);
    rq_t r;
    reader_model_i.send(c, bad);
    reader_model_i.recv(DLY + 120, r);
    chk_q(r, e);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (k == 50) tmo();
    bready <= 1'b0;
    chk(bresp, e);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (k == 50) tmo();
    rready <= 1'b0;
    chk(rdata, e);
    chk(rresp, er);
  endtask
  task automatic pg(input logic [7:0] p, input logic w, input logic e);
    @(posedge aclk);
    page <= p;
    page_write <= w;
    repeat (2) @(posedge aclk);
    chk(page_ok, e);
  endtask
  initial begin
    #500000;
    tmo();
  end
  initial begin
    for (int i = 0; i < 32; i++) se.push_back({1'b0, SIG[8*i +: 8]});
    vq = {`OP_VCS};
    repeat (20) vq.push_back(8'h77);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_CONFIG, 32'h0000_00FF, 2'h0);
    rd(5'h1C, 32'h0, 2'h2);
    wr(`OFS_STATUS, 32'h1, 2'h2);
    wr(`OFS_CONFIG, 32'h0000_0510, 2'h0);
    wr(`OFS_PASSWORD, 32'h1122_3344, 2'h0);
    wr(`OFS_ANSWER, 32'h0000_1234, 2'h0);
    rd(`OFS_PASSWORD, 32'h0, 2'h0);
    cmd('{`OP_READ, 8'h00}, '{9'h000, 9'h000, 9'h000});
    cmd('{`OP_INCR, 8'h00, 8'h01, 8'h02, 8'h03, 8'hAA}, nib(`ACK_CODE));
    cmd('{`OP_INCR, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, nib(`ACK_CODE));
    cmd('{`OP_READ, 8'h00}, '{9'h001, 9'h002, 9'h003});
    cmd('{`OP_INCR, 8'h00, 8'hFF, 8'hFD, 8'h0C, 8'h00}, nib(`NAK_ARG));
    cmd('{`OP_INCR, 8'h00, 8'hFE, 8'hFD, 8'h0C, 8'h00}, nib(`ACK_CODE));
    cmd('{`OP_INCR, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00}, nib(`NAK_ARG));
    cmd('{`OP_INCR, 8'h03, 8'h01, 8'h00, 8'h00, 8'h00}, nib(`NAK_ARG));
    cmd('{`OP_READ, 8'h03}, nib(`NAK_ARG));
    cmd('{`OP_TEAR, 8'h03}, nib(`NAK_ARG));
    cmd('{`OP_READ, 8'h00}, nib(`NAK_CRC), 1'b1);
    reader_model_i.slow = 1'b1;
    cmd('{`OP_SIG, 8'h00}, se);
    reader_model_i.slow = 1'b0;
    cmd('{`OP_SIG, 8'h01}, nib(`NAK_ARG));
    cmd(vq, '{{1'b0, CT}});
    void'(vq.pop_back());
    cmd(vq, nib(`NAK_ARG));
    cmd('{`OP_TEAR, 8'h01}, '{{1'b0, `TEAR_OK}});
    fork
      cmd('{`OP_INCR, 8'h01, 8'h05, 8'h00, 8'h00, 8'h00}, none);
      begin
        @(posedge aclk iff rx_end);
        repeat (2) @(posedge aclk);
        field_lost <= 1'b1;
        repeat (6) @(posedge aclk);
        field_lost <= 1'b0;
      end
    join
    cmd('{`OP_TEAR, 8'h01}, '{9'h000});
    cmd('{`OP_READ, 8'h01}, '{9'h000, 9'h000, 9'h000});
    pg(8'h05, 1'b1, 1'b1);
    pg(8'h20, 1'b0, 1'b0);
    cmd('{`OP_PWD, 8'h44, 8'h33, 8'h22, 8'h11}, '{9'h034, 9'h012});
    pg(8'h20, 1'b1, 1'b1);
    @(posedge aclk);
    session_end <= 1'b1;
    @(posedge aclk);
    session_end <= 1'b0;
    pg(8'h20, 1'b1, 1'b0);
    repeat (2) cmd('{`OP_PWD, 8'h00, 8'h00, 8'h00, 8'h00}, nib(`NAK_ARG));
    cmd('{`OP_PWD, 8'h44, 8'h33, 8'h22, 8'h11}, nib(`NAK_ARG));
    rd(`OFS_STATUS, 32'h0000_0054, 2'h0);
    cmd('{`OP_READ, 8'h00}, '{9'h0FF, 9'h0FF, 9'h00F});
    results();
  end
endmodule
bind ticket_cmd ticket_cmd_props #(.RESP_DELAY_CYC(RESP_DELAY_CYC)) ticket_cmd_props_i (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .rx_end(rx_end), .tx(tx), .tx_ready(tx_ready));
